// [pkg/tas_map.svh]
// Offsets, field positions, reset values and timing counts of the trigger sequencer.
`ifndef TAS_MAP_SVH
`define TAS_MAP_SVH

// Register byte offsets on the APB port.
`define TAS_OFS_CTRL        12'h000
`define TAS_OFS_HOLD        12'h004
`define TAS_OFS_STATUS      12'h008

// Control register fields.
`define TAS_CTRL_ROUTE_LSB  0
`define TAS_CTRL_ACCEPT_BIT 2
`define TAS_CTRL_GATE_BIT   3
`define TAS_CTRL_BURST_BIT  4
`define TAS_CTRL_WIDTH      5
`define TAS_CTRL_RST        5'h00

// Hold switch register fields.
`define TAS_HOLD_WIDTH      4
`define TAS_HOLD_RST        4'h1

// Status register fields.
`define TAS_STAT_ARMED_BIT  0
`define TAS_STAT_HELD_BIT   1
`define TAS_STAT_BEGIN_BIT  2
`define TAS_STAT_END_BIT    3
`define TAS_STAT_INH_BIT    4
`define TAS_STAT_BURST_BIT  5

// Clock period and trigger settling delay, both in nanoseconds.
`define TAS_CLK_PERIOD_NS   40
`define TAS_TRIG_DELAY_NS   4
// Least delay rounds up to whole cycles, never below one.
`define TAS_TRIG_DELAY_CYC  (((`TAS_TRIG_DELAY_NS + `TAS_CLK_PERIOD_NS - 1) / `TAS_CLK_PERIOD_NS) < 1 ? 1 : ((`TAS_TRIG_DELAY_NS + `TAS_CLK_PERIOD_NS - 1) / `TAS_CLK_PERIOD_NS))

`endif

// [pkg/tas_pkg.sv]
// Types shared by the trigger arm and synchroniser sequencer.
package tas_pkg;

    // Routing of the selected trigger.
    typedef enum logic [1:0] {
        TAS_ROUTE_RATE = 2'b00,
        TAS_ROUTE_LINE = 2'b01,
        TAS_ROUTE_EXT  = 2'b10,
        TAS_ROUTE_OFF  = 2'b11
    } tas_route_t;

    // Progress of one timing cycle.
    typedef enum logic [1:0] {
        TAS_CYC_IDLE  = 2'b00,
        TAS_CYC_HELD  = 2'b01,
        TAS_CYC_BEGIN = 2'b10,
        TAS_CYC_RUN   = 2'b11
    } tas_cyc_t;

endpackage

// [core/tas_sync2.sv]
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/10ps
`default_nettype none

module tas_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous levels in, synchronised levels out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // First stage is read only by the second stage.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= '0;
            q      <= '0;
        end
        else
        begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

`default_nettype wire

// [core/tas_sequencer.sv]
// Trigger selection, arming, capture and ramp synchroniser with an APB register port.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "tas_map.svh"

//////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Route rate, line/single or external trigger to selected trigger and a copy.
// - Trigger capture happens only while the arm condition is true.
// - Arm needs accept enable, and no inhibit when the inhibit gate is on.
// - Inhibit input passes the two-flop synchroniser and one more flip-flop, then goes out for blanking.
// - A separate unsynchronised inhibit copy goes out for rate error checks.
// - Capture flop set by armed trigger holds for the cycle, enabling later stages.
// - Delayed trigger clocks capture into ramp-begin, which stays unsynchronised.
// - Ramp-begin passes two timebase flip-flops in series.
// - Ramp-end marker follows ramp-begin and is synchronous to the timebase.
// - Active-low cycle abort clears any cycle in progress.
// - Cycle done clears the converter and readies the next cycle.
// - In burst mode the cycle lasts until the final burst pulse is marked.
//////////////////////////////////////////////////////////////////////////////////////////

module tas_sequencer #(
    parameter int DLY_CYC = `TAS_TRIG_DELAY_CYC
) (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB register port.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Trigger sources.
    input  wire logic        internal_rate,
    input  wire logic        line_or_single_trigger,
    input  wire logic        external_trigger,
    // Inhibit input and its copies.
    input  wire logic        inhibit_input,
    output logic             inhibit_synced,
    output logic             inhibit_raw,
    // Cycle control from the timing controller.
    input  wire logic        cycle_abort_n,
    input  wire logic        cycle_done,
    input  wire logic        final_burst_pulse,
    // Trigger and ramp outputs.
    output logic             selected_trigger,
    output logic             selected_trigger_copy,
    output logic             ramp_begin,
    output logic             ramp_end,
    // Hold switch controls.
    output logic      [3:0]  hold_switch_ctrl
);

    //////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation.

    logic [6:0] pins_s;
    logic       rate_s;
    logic       line_s;
    logic       ext_s;
    logic       inh_s;
    logic       abort_n_s;
    logic       done_s;
    logic       last_s;

    tas_sync2 #(
        .W (7)
    ) u_pin_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({final_burst_pulse, cycle_done, cycle_abort_n, inhibit_input,
                 external_trigger, line_or_single_trigger, internal_rate}),
        .q     (pins_s)
    );

    // Split the synchronised pins by use.
    assign rate_s    = pins_s[0];
    assign line_s    = pins_s[1];
    assign ext_s     = pins_s[2];
    assign inh_s     = pins_s[3];
    assign abort_n_s = pins_s[4];
    assign done_s    = pins_s[5];
    assign last_s    = pins_s[6];

    //////////////////////////////////////////////////////////////////////////////////////
    // Registers written by software.

    logic [`TAS_CTRL_WIDTH-1:0] ctrl_q;
    logic [`TAS_HOLD_WIDTH-1:0] hold_q;
    tas_pkg::tas_route_t        route;
    logic                       accept_en;
    logic                       gate_en;
    logic                       burst_en;
    logic                       acc_phase;
    logic                       wr_en;
    logic                       hit_ctrl;
    logic                       hit_hold;
    logic                       hit_stat;

    // Decode the control fields.
    assign route     = tas_pkg::tas_route_t'(ctrl_q[`TAS_CTRL_ROUTE_LSB +: 2]);
    assign accept_en = ctrl_q[`TAS_CTRL_ACCEPT_BIT];
    assign gate_en   = ctrl_q[`TAS_CTRL_GATE_BIT];
    assign burst_en  = ctrl_q[`TAS_CTRL_BURST_BIT];

    // Address decode and the edge at which a write takes effect.
    assign acc_phase = psel & penable;
    assign wr_en     = acc_phase & pready & pwrite;
    assign hit_ctrl  = (paddr == `TAS_OFS_CTRL);
    assign hit_hold  = (paddr == `TAS_OFS_HOLD);
    assign hit_stat  = (paddr == `TAS_OFS_STATUS);

    // Control and hold switch registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `TAS_CTRL_RST;
            hold_q <= `TAS_HOLD_RST;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)
                ctrl_q <= pwdata[`TAS_CTRL_WIDTH-1:0];
            if (hit_hold)
                hold_q <= pwdata[`TAS_HOLD_WIDTH-1:0];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Trigger routing and arming.

    logic sel_d;
    logic sel_q;
    logic armed;

    // Pick one trigger source.
    always_comb
    begin
        unique case (route)
            tas_pkg::TAS_ROUTE_RATE: sel_d = rate_s;
            tas_pkg::TAS_ROUTE_LINE: sel_d = line_s;
            tas_pkg::TAS_ROUTE_EXT:  sel_d = ext_s;
            tas_pkg::TAS_ROUTE_OFF:  sel_d = 1'b0;
        endcase
    end

    // Selected trigger and its replica for the controller.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_q                 <= 1'b0;
            selected_trigger      <= 1'b0;
            selected_trigger_copy <= 1'b0;
        end
        else
        begin
            sel_q                 <= sel_d;
            selected_trigger      <= sel_d;
            selected_trigger_copy <= sel_d;
        end
    end

    // Arm needs accept enable, and a quiet inhibit when gating is on.
    assign armed = accept_en & ~(gate_en & inh_s);

    // Inhibit copies for blanking and for rate error checks.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inhibit_synced <= 1'b0;
            inhibit_raw    <= 1'b0;
        end
        else
        begin
            inhibit_synced <= inh_s;
            inhibit_raw    <= inhibit_input;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Trigger settling delay.

    logic [DLY_CYC:0] dly;
    logic             dly_prev_q;
    logic             dly_rise;

    assign dly[0] = sel_q;

    // One flip-flop per stage of settling delay.
    generate
        for (genvar i = 0; i < DLY_CYC; i++)
        begin : g_dly
            logic stage_q;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    stage_q <= 1'b0;
                else
                    stage_q <= dly[i];
            end
            assign dly[i+1] = stage_q;
        end
    endgenerate

    // Rising edge of the delayed trigger.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            dly_prev_q <= 1'b0;
        else
            dly_prev_q <= dly[DLY_CYC];
    end

    assign dly_rise = dly[DLY_CYC] & ~dly_prev_q;

    //////////////////////////////////////////////////////////////////////////////////////
    // Cycle sequence.

    tas_pkg::tas_cyc_t cyc_q;
    tas_pkg::tas_cyc_t cyc_d;
    logic              trig_rise;
    logic              cyc_end;
    logic              begin_s1_q;

    assign trig_rise = sel_d & ~sel_q;
    // In burst mode only the final pulse ends the cycle.
    assign cyc_end   = done_s & (~burst_en | last_s);

    // Capture, ramp begin and ramp end stepping.
    always_comb
    begin
        cyc_d = cyc_q;
        unique case (cyc_q)
            tas_pkg::TAS_CYC_IDLE:
                if (trig_rise & armed)
                    cyc_d = tas_pkg::TAS_CYC_HELD;
            tas_pkg::TAS_CYC_HELD:
                if (dly_rise)
                    cyc_d = tas_pkg::TAS_CYC_BEGIN;
            tas_pkg::TAS_CYC_BEGIN:
                if (ramp_end)
                    cyc_d = tas_pkg::TAS_CYC_RUN;
            tas_pkg::TAS_CYC_RUN:
                cyc_d = tas_pkg::TAS_CYC_RUN;
        endcase
        if (cyc_q != tas_pkg::TAS_CYC_IDLE && cyc_end)
            cyc_d = tas_pkg::TAS_CYC_IDLE;
        if (!abort_n_s)
            cyc_d = tas_pkg::TAS_CYC_IDLE;
    end

    // Cycle state register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cyc_q <= tas_pkg::TAS_CYC_IDLE;
        else
            cyc_q <= cyc_d;
    end

    // Ramp begin from the delayed trigger while the capture is held.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ramp_begin <= 1'b0;
        else
            ramp_begin <= (cyc_d == tas_pkg::TAS_CYC_BEGIN) |
                          (cyc_d == tas_pkg::TAS_CYC_RUN);
    end

    // Two timebase stages in series produce the ramp end marker.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            begin_s1_q <= 1'b0;
            ramp_end   <= 1'b0;
        end
        else
        begin
            begin_s1_q <= ramp_begin & (cyc_d != tas_pkg::TAS_CYC_IDLE);
            ramp_end   <= begin_s1_q & (cyc_d != tas_pkg::TAS_CYC_IDLE);
        end
    end

    // Hold switch controls follow software; the controller sequences them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_switch_ctrl <= `TAS_HOLD_RST;
        else
            hold_switch_ctrl <= hold_q;
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // APB answer.

    logic [31:0] rd_d;

    // Read data mux; reserved bits read as zero.
    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (hit_ctrl)
            rd_d[`TAS_CTRL_WIDTH-1:0] = ctrl_q;
        if (hit_hold)
            rd_d[`TAS_HOLD_WIDTH-1:0] = hold_q;
        if (hit_stat)
        begin
            rd_d[`TAS_STAT_ARMED_BIT] = armed;
            rd_d[`TAS_STAT_HELD_BIT]  = (cyc_q != tas_pkg::TAS_CYC_IDLE);
            rd_d[`TAS_STAT_BEGIN_BIT] = ramp_begin;
            rd_d[`TAS_STAT_END_BIT]   = ramp_end;
            rd_d[`TAS_STAT_INH_BIT]   = inh_s;
            rd_d[`TAS_STAT_BURST_BIT] = burst_en;
        end
    end

    // Ready comes one cycle into the access phase, with data and error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= acc_phase & ~pready;
            if (acc_phase & ~pready)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= ~(hit_ctrl | hit_hold | (hit_stat & ~pwrite));
            end
            else
            begin
                prdata  <= 32'h0000_0000;
                pslverr <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// [test/tas_sequencer_chk.sv]
// Port-level assertions for the trigger sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "tas_map.svh"

module tas_sequencer_chk (
    // Clock, reset and APB port.
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Pins.
    input wire logic        inhibit_input,
    input wire logic        inhibit_synced,
    input wire logic        inhibit_raw,
    input wire logic        cycle_abort_n,
    input wire logic        selected_trigger,
    input wire logic        selected_trigger_copy,
    input wire logic        ramp_begin,
    input wire logic        ramp_end,
    input wire logic [3:0]  hold_switch_ctrl
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A write to the hold register completes on this edge.
    logic hold_wr;
    assign hold_wr = psel && penable && pready && pwrite && paddr == `TAS_OFS_HOLD;

    // Steps of a capture: the trigger rose two edges before ramp-begin.
    sequence ramp_up_s;
        $rose(ramp_begin);
    endsequence
    sequence trig_rose_s;
        $past(selected_trigger, 2) && !$past(selected_trigger, 3);
    endsequence

    copy_match_a: assert property (selected_trigger_copy == selected_trigger)
        else $error("trigger copy differs from selected trigger");
    raw_inhibit_a: assert property ($past(presetn) |-> inhibit_raw == $past(inhibit_input))
        else $error("raw inhibit is not one flop behind the pin");
    sync_inhibit_a: assert property ($past(presetn, 3) |-> inhibit_synced == $past(inhibit_input, 3))
        else $error("synced inhibit is not three flops behind the pin");
    begin_cause_a: assert property (ramp_up_s |-> trig_rose_s)
        else $error("ramp begin without a captured trigger");
    end_follow_a: assert property (ramp_up_s |-> ##2 $rose(ramp_end))
        else $error("ramp end not two clocks after ramp begin");
    abort_clear_a: assert property (!cycle_abort_n [*8] |-> !ramp_begin && !ramp_end)
        else $error("abort did not clear the cycle");
    hold_write_a: assert property (!$stable(hold_switch_ctrl) |-> $past(hold_wr) || $past(hold_wr, 2))
        else $error("hold switches moved without a write");
    ready_time_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("access phase is not two cycles");
    idle_read_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside the answer cycle");
endmodule

bind tas_sequencer tas_sequencer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .inhibit_input(inhibit_input), .inhibit_synced(inhibit_synced), .inhibit_raw(inhibit_raw),
    .cycle_abort_n(cycle_abort_n), .selected_trigger(selected_trigger),
    .selected_trigger_copy(selected_trigger_copy), .ramp_begin(ramp_begin),
    .ramp_end(ramp_end), .hold_switch_ctrl(hold_switch_ctrl));
`default_nettype wire

// [test/tas_far_side.sv]
// Behavioural timing controller and trigger sources facing the sequencer.
`timescale 1ns/10ps
`default_nettype none

module tas_far_side (
    // Clock, reset and bench commands.
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       fire,
    input wire logic [1:0] fire_src,
    input wire logic       pick_line,
    input wire logic       abort_req,
    input wire logic [3:0] burst_len,
    // Sequencer side.
    input wire logic       ramp_end,
    output logic           internal_rate,
    output logic           line_or_single_trigger,
    output logic           external_trigger,
    output logic           cycle_abort_n,
    output logic           cycle_done,
    output logic           final_burst_pulse
);
    logic [2:0] pulse_q;
    logic [1:0] src_q;
    logic [3:0] init_q;
    logic [8:0] cnt_q;

    // A source pulse lasts six clocks so the synchroniser cannot miss it.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            pulse_q <= 3'h0;
        else if (fire)
            pulse_q <= 3'h6;
        else if (pulse_q != 3'h0)
            pulse_q <= pulse_q - 3'h1;
    always_ff @(posedge pclk)
        if (fire)
            src_q <= fire_src;

    // Abort is held after power-up and on request; coarse count runs on ramp end.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            init_q <= 4'hF;
        else if (init_q != 4'h0)
            init_q <= init_q - 4'h1;
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            cnt_q <= 9'h000;
        else
            cnt_q <= ramp_end ? cnt_q + 9'h001 : 9'h000;

    // The line and single-shot triggers share one wire, picked here.
    assign internal_rate = pulse_q != 3'h0 && src_q == 2'h0;
    assign line_or_single_trigger = pulse_q != 3'h0 &&
                                    (pick_line ? src_q == 2'h1 : src_q == 2'h3);
    assign external_trigger = pulse_q != 3'h0 && src_q == 2'h2;
    assign cycle_abort_n = !(abort_req || init_q != 4'h0);
    assign cycle_done = ramp_end && cnt_q[4:0] >= 5'h1A;
    assign final_burst_pulse = cycle_done && cnt_q[8:5] == burst_len;
endmodule
`default_nettype wire

// [test/tas_sequencer_test.sv]
// Self-checking bench for the trigger sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "tas_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module tas_sequencer_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, pick_line;
    logic        internal_rate, line_or_single_trigger, external_trigger, inhibit_input;
    logic        inhibit_synced, inhibit_raw, cycle_abort_n, cycle_done, final_burst_pulse;
    logic        selected_trigger, selected_trigger_copy, ramp_begin, ramp_end, abort_req;
    logic [1:0]  fire_src;
    logic [3:0]  hold_switch_ctrl, burst_len;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  hold_seq [4] = '{4'h1, 4'h2, 4'hE, 4'h1};
    int          bad_count, total_checks, len;

    tas_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .internal_rate(internal_rate),
        .line_or_single_trigger(line_or_single_trigger), .external_trigger(external_trigger),
        .inhibit_input(inhibit_input), .inhibit_synced(inhibit_synced),
        .inhibit_raw(inhibit_raw), .cycle_abort_n(cycle_abort_n), .cycle_done(cycle_done),
        .final_burst_pulse(final_burst_pulse), .selected_trigger(selected_trigger),
        .selected_trigger_copy(selected_trigger_copy), .ramp_begin(ramp_begin),
        .ramp_end(ramp_end), .hold_switch_ctrl(hold_switch_ctrl));
    tas_far_side u_far (.pclk(pclk), .presetn(presetn), .fire(fire), .fire_src(fire_src),
        .pick_line(pick_line), .abort_req(abort_req), .burst_len(burst_len),
        .ramp_end(ramp_end), .internal_rate(internal_rate),
        .line_or_single_trigger(line_or_single_trigger), .external_trigger(external_trigger),
        .cycle_abort_n(cycle_abort_n), .cycle_done(cycle_done),
        .final_burst_pulse(final_burst_pulse));

    // Clock at 25 MHz.
    always #20 pclk = !pclk;

    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer, then a compare of read data on reads and of the error response.
    // It waits for pready however long that takes; only the watchdog ends a hang.
    task automatic rw(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (!w)
            `CHK(prdata, exp)
        `CHK(pslverr, err)
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One trigger pulse from the chosen source.
    task automatic pulse(input logic [1:0] s);
        @(posedge pclk);
        fire <= 1'b1;
        fire_src <= s;
        @(posedge pclk);
        fire <= 1'b0;
    endtask

    // External trigger cycle; a second trigger while held must be ignored.
    task automatic run_cycle(input logic [31:0] ctrl, output int len);
        rw(1'b1, `TAS_OFS_CTRL, ctrl, 32'h0, 1'b0);
        pulse(2'h2);
        repeat (9) @(negedge pclk);
        `CHK(ramp_end, 1'b1)
        rw(1'b0, `TAS_OFS_STATUS, 32'h0, {26'h0, ctrl[4], 5'hF}, 1'b0);
        pulse(2'h2);
        len = 0;
        while (ramp_begin === 1'b1 && len < 300)
        begin
            @(negedge pclk);
            len++;
        end
        `CHK(len < 300, 1'b1)
        repeat (10) @(negedge pclk);
        `CHK(ramp_begin, 1'b0)
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end

    // Main sequence.
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, fire, pick_line, abort_req} = 8'h00;
        {inhibit_input, fire_src, burst_len, paddr, pwdata} = 51'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        rw(1'b0, `TAS_OFS_CTRL, 32'h0, 32'h0, 1'b0);
        rw(1'b0, `TAS_OFS_HOLD, 32'h0, 32'h1, 1'b0);
        rw(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        rw(1'b1, `TAS_OFS_STATUS, 32'h3F, 32'h0, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            inhibit_input <= i[0];
            rw(1'b1, `TAS_OFS_CTRL, {28'h0, i[2], i[1], 2'h2}, 32'h0, 1'b0);
            repeat (4) @(negedge pclk);
            `CHK(inhibit_raw, i[0])
            `CHK(inhibit_synced, i[0])
            rw(1'b0, `TAS_OFS_STATUS, 32'h0, {27'h0, i[0], 3'h0, i[1] && !(i[2] && i[0])}, 1'b0);
        end
        pulse(2'h2);
        repeat (10) @(negedge pclk);
        `CHK(ramp_begin, 1'b0)
        inhibit_input <= 1'b0;
        for (int r = 0; r < 4; r++)
            for (int s = 0; s < 3; s++)
            begin
                pick_line <= r[0];
                rw(1'b1, `TAS_OFS_CTRL, r, 32'h0, 1'b0);
                pulse(s[1:0]);
                repeat (5) @(negedge pclk);
                `CHK(selected_trigger, logic'(r == s))
                `CHK(ramp_begin, 1'b0)
                repeat (8) @(negedge pclk);
            end
        pick_line <= 1'b0;
        rw(1'b1, `TAS_OFS_CTRL, 32'h1, 32'h0, 1'b0);
        pulse(2'h3);
        repeat (5) @(negedge pclk);
        `CHK(selected_trigger, 1'b1)
        repeat (8) @(negedge pclk);
        run_cycle(32'h0000_0006, len);
        `CHK(len < 50, 1'b1)
        burst_len <= 4'h2;
        run_cycle(32'h0000_0016, len);
        `CHK(len > 60, 1'b1)
        burst_len <= 4'h0;
        rw(1'b1, `TAS_OFS_CTRL, 32'h0000_0006, 32'h0, 1'b0);
        pulse(2'h2);
        repeat (10) @(posedge pclk);
        abort_req <= 1'b1;
        repeat (10) @(negedge pclk);
        `CHK({ramp_begin, ramp_end}, 2'h0)
        @(posedge pclk);
        abort_req <= 1'b0;
        rw(1'b0, `TAS_OFS_STATUS, 32'h0, 32'h1, 1'b0);
        foreach (hold_seq[k])
        begin
            rw(1'b1, `TAS_OFS_HOLD, {28'h0, hold_seq[k]}, 32'h0, 1'b0);
            repeat (2) @(negedge pclk);
            `CHK(hold_switch_ctrl, hold_seq[k])
        end
        wrap_up();
    end
endmodule
`default_nettype wire
